/* File: core/cisd_decode.v */
// Compact instruction decoder with wide/compact execution state control.
`include "cisd_map.vh"
module cisd_decode (
  input  wire        ref_clk,
  input  wire        reset_n,
  input  wire        fetch_valid,
  input  wire [31:0] fetch_word,
  input  wire [31:0] program_counter,
  input  wire [31:0] stack_pointer,
  input  wire [3:0]  flags_nzcv,
  input  wire [31:0] xchg_target_low,
  input  wire [31:0] xchg_target_high,
  input  wire        exc_enter,
  input  wire        exc_return,
  input  wire [31:0] load_data,
  output reg         state_compact_ff,
  output reg  [31:0] fetch_addr_ff,
  output reg  [15:0] instr_ff,
  output reg         wide_instr_ff,
  output reg  [31:0] wide_word_ff,
  output reg         branch_taken_ff,
  output reg  [31:0] branch_target_ff,
  output reg         xchg_branch_ff,
  output reg  [1:0]  shift_op_ff,
  output reg         shift_by_reg_ff,
  output reg  [4:0]  shift_imm_ff,
  output reg  [1:0]  ls_size_ff,
  output reg  [9:0]  ls_offset_ff,
  output reg         ls_load_ff,
  output reg         addr_gen_ff,
  output reg  [31:0] addr_gen_value_ff,
  output reg         push_ff,
  output reg         pop_ff,
  output reg  [7:0]  reg_list_ff,
  output reg         push_link_ff,
  output reg         pop_pc_ff,
  output reg  [31:0] signed_load_ff
);
  reg         saved_compact_ff;
  reg  [15:0] half;
  reg         nxt_state;
  reg  [31:0] nxt_fetch_addr;
  wire        cond_taken;
  wire        is_cond_br;
  wire        is_uncond_br;
  wire        is_xchg;
  wire        is_shift;
  wire        is_alu_shift;
  wire        is_imm_ls;
  wire        is_half_ls;
  wire        is_pcrel_ld;
  wire        is_sprel_ls;
  wire        is_addr_gen;
  wire        is_push_pop;
  wire        is_signed_ld;
  wire [31:0] xchg_target;
  wire [31:0] cond_ofs;
  wire [31:0] uncond_ofs;
  wire [31:0] pc_word;
  wire [31:0] ofs10;
  wire        signed_half;
  wire        wide_cond_taken;
  wire        is_wide_xchg;
  wire [31:0] wide_target;

  always @* begin
    if (program_counter[`CISD_PC_HALF_BIT]) begin
      half = fetch_word[31:16];
    end else begin
      half = fetch_word[15:0];
    end
  end

  cisd_cond_eval u_cond (
    .cond   (half[11:8]),
    .flag_n (flags_nzcv[3]),
    .flag_z (flags_nzcv[2]),
    .flag_c (flags_nzcv[1]),
    .flag_v (flags_nzcv[0]),
    .taken  (cond_taken)
  );

  // Wide words are checked only for the exchange branch, which sets the state from bit 0 of its target.
  cisd_cond_eval u_cond_wide (
    .cond   (fetch_word[31:28]),
    .flag_n (flags_nzcv[3]),
    .flag_z (flags_nzcv[2]),
    .flag_c (flags_nzcv[1]),
    .flag_v (flags_nzcv[0]),
    .taken  (wide_cond_taken)
  );

  assign is_cond_br   = (half[15:12] == 4'hd) && (half[11:9] != 3'h7);
  assign is_uncond_br = (half[15:11] == 5'h1c);
  assign is_xchg      = (half[15:8] == 8'h47);
  assign is_shift     = (half[15:13] == 3'h0) && (half[12:11] != 2'h3);
  assign is_alu_shift = (half[15:10] == 6'h10) &&
                        ((half[9:6] == 4'h2) || (half[9:6] == 4'h3) ||
                         (half[9:6] == 4'h4) || (half[9:6] == 4'h7));
  assign is_imm_ls    = (half[15:13] == 3'h3);
  assign is_half_ls   = (half[15:12] == 4'h8);
  assign is_pcrel_ld  = (half[15:11] == 5'h09);
  assign is_sprel_ls  = (half[15:12] == 4'h9);
  assign is_addr_gen  = (half[15:12] == 4'ha);
  assign is_push_pop  = (half[15:12] == 4'hb) && (half[10:9] == 2'h2);
  assign is_signed_ld = (half[15:12] == 4'h5) && half[10] && half[9];
  assign signed_half  = half[11];
  assign is_wide_xchg = (fetch_word[27:4] == `CISD_WIDE_XCHG) &&
                        ((fetch_word[31:28] == `CISD_COND_AL) || wide_cond_taken);
  assign wide_target  = fetch_word[3] ? xchg_target_high : xchg_target_low;
  assign xchg_target  = half[6] ? xchg_target_high : xchg_target_low;
  assign cond_ofs     = {{23{half[7]}}, half[7:0], 1'b0};
  assign uncond_ofs   = {{20{half[10]}}, half[10:0], 1'b0};
  assign pc_word      = {program_counter[31:2], 2'h0};
  assign ofs10        = {22'h0, half[7:0], 2'h0};

  always @* begin
    nxt_state = state_compact_ff;
    if (exc_enter) begin
      nxt_state = `CISD_STATE_WIDE;
    end else if (exc_return) begin
      nxt_state = saved_compact_ff;
    end else if (fetch_valid && state_compact_ff && is_xchg) begin
      nxt_state = xchg_target[0];
    end else if (fetch_valid && !state_compact_ff && is_wide_xchg) begin
      nxt_state = wide_target[0];
    end
  end

  always @* begin
    if (state_compact_ff) begin
      nxt_fetch_addr = {program_counter[31:1], 1'b0};
    end else begin
      nxt_fetch_addr = {program_counter[31:2], 2'h0};
    end
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      saved_compact_ff <= `CISD_RESET_STATE;
    end else if (exc_enter) begin
      saved_compact_ff <= state_compact_ff;
    end
  end

  // Only the state bit changes here; no mode or register value is touched.
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_compact_ff <= `CISD_RESET_STATE;
    end else begin
      state_compact_ff <= nxt_state;
    end
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      fetch_addr_ff     <= 32'h0;
      instr_ff          <= 16'h0;
      wide_instr_ff     <= 1'b0;
      wide_word_ff      <= 32'h0;
      branch_taken_ff   <= 1'b0;
      branch_target_ff  <= 32'h0;
      xchg_branch_ff    <= 1'b0;
      shift_op_ff       <= 2'h0;
      shift_by_reg_ff   <= 1'b0;
      shift_imm_ff      <= 5'h0;
      ls_size_ff        <= `CISD_LS_NONE;
      ls_offset_ff      <= 10'h0;
      ls_load_ff        <= 1'b0;
      addr_gen_ff       <= 1'b0;
      addr_gen_value_ff <= 32'h0;
      push_ff           <= 1'b0;
      pop_ff            <= 1'b0;
      reg_list_ff       <= 8'h0;
      push_link_ff      <= 1'b0;
      pop_pc_ff         <= 1'b0;
      signed_load_ff    <= 32'h0;
    end else begin
      fetch_addr_ff   <= nxt_fetch_addr;
      wide_instr_ff   <= fetch_valid & ~state_compact_ff;
      branch_taken_ff <= 1'b0;
      xchg_branch_ff  <= 1'b0;
      addr_gen_ff     <= 1'b0;
      push_ff         <= 1'b0;
      pop_ff          <= 1'b0;
      push_link_ff    <= 1'b0;
      pop_pc_ff       <= 1'b0;
      ls_size_ff      <= `CISD_LS_NONE;
      shift_by_reg_ff <= 1'b0;
      if (fetch_valid && !state_compact_ff) begin
        wide_word_ff <= fetch_word;
        if (is_wide_xchg) begin
          branch_taken_ff  <= 1'b1;
          xchg_branch_ff   <= 1'b1;
          branch_target_ff <= {wide_target[31:1], 1'b0};
        end
      end
      if (fetch_valid && state_compact_ff) begin
        instr_ff <= half;
        if (is_cond_br) begin
          branch_taken_ff  <= cond_taken;
          branch_target_ff <= program_counter + cond_ofs;
        end
        if (is_uncond_br) begin
          branch_taken_ff  <= 1'b1;
          branch_target_ff <= program_counter + uncond_ofs;
        end
        if (is_xchg) begin
          branch_taken_ff  <= 1'b1;
          xchg_branch_ff   <= 1'b1;
          branch_target_ff <= {xchg_target[31:1], 1'b0};
        end
        if (is_shift) begin
          shift_op_ff  <= half[12:11];
          shift_imm_ff <= half[10:6];
        end
        if (is_alu_shift) begin
          shift_by_reg_ff <= 1'b1;
          case (half[9:6])
            4'h2:    shift_op_ff <= `CISD_OP_SHIFT_LL;
            4'h3:    shift_op_ff <= `CISD_OP_SHIFT_RL;
            4'h4:    shift_op_ff <= `CISD_OP_SHIFT_RA;
            default: shift_op_ff <= `CISD_OP_ROTATE_R;
          endcase
        end
        if (is_imm_ls) begin
          ls_load_ff <= half[11];
          if (half[12]) begin
            ls_size_ff   <= `CISD_LS_BYTE;
            ls_offset_ff <= {5'h0, half[10:6]};
          end else begin
            ls_size_ff   <= `CISD_LS_WORD;
            ls_offset_ff <= {3'h0, half[10:6], 2'h0};
          end
        end
        if (is_half_ls) begin
          ls_load_ff   <= half[11];
          ls_size_ff   <= `CISD_LS_HALF;
          ls_offset_ff <= {4'h0, half[10:6], 1'b0};
        end
        if (is_pcrel_ld || is_sprel_ls) begin
          ls_load_ff   <= is_pcrel_ld | half[11];
          ls_size_ff   <= `CISD_LS_WORD;
          ls_offset_ff <= ofs10[9:0];
        end
        if (is_addr_gen) begin
          addr_gen_ff <= 1'b1;
          if (half[11]) begin
            addr_gen_value_ff <= stack_pointer + ofs10;
          end else begin
            addr_gen_value_ff <= pc_word + ofs10;
          end
        end
        if (is_push_pop) begin
          reg_list_ff <= half[7:0];
          if (half[11]) begin
            pop_ff    <= 1'b1;
            pop_pc_ff <= half[8];
          end else begin
            push_ff      <= 1'b1;
            push_link_ff <= half[8];
          end
        end
      end
      if (fetch_valid && is_signed_ld && state_compact_ff) begin
        if (signed_half) begin
          signed_load_ff <= {{16{load_data[15]}}, load_data[15:0]};
        end else begin
          signed_load_ff <= {{24{load_data[7]}}, load_data[7:0]};
        end
      end
    end
  end
endmodule

/* File: core/cisd_map.vh */
// Encoding fields, condition codes and state constants of the compact instruction decoder.
`ifndef CISD_MAP_VH
`define CISD_MAP_VH
`define CISD_STATE_WIDE       1'b0
`define CISD_STATE_COMPACT    1'b1
`define CISD_RESET_STATE      1'b0
`define CISD_PC_HALF_BIT      1
`define CISD_SHIFT_IMM_BITS   5
`define CISD_OFS_WORD_BITS    7
`define CISD_OFS_HALF_BITS    6
`define CISD_OFS_BYTE_BITS    5
`define CISD_OFS_PCSP_BITS    10
`define CISD_OFS_UNCOND_BITS  11
`define CISD_COND_EQ          4'h0
`define CISD_COND_NE          4'h1
`define CISD_COND_CS          4'h2
`define CISD_COND_CC          4'h3
`define CISD_COND_MI          4'h4
`define CISD_COND_PL          4'h5
`define CISD_COND_VS          4'h6
`define CISD_COND_VC          4'h7
`define CISD_COND_HI          4'h8
`define CISD_COND_LS          4'h9
`define CISD_COND_GE          4'ha
`define CISD_COND_LT          4'hb
`define CISD_COND_GT          4'hc
`define CISD_COND_LE          4'hd
`define CISD_OP_SHIFT_LL      2'h0
`define CISD_OP_SHIFT_RL      2'h1
`define CISD_OP_SHIFT_RA      2'h2
`define CISD_OP_ROTATE_R      2'h3
`define CISD_LS_WORD          2'h0
`define CISD_LS_HALF          2'h1
`define CISD_LS_BYTE          2'h2
`define CISD_LS_NONE          2'h3
`define CISD_COND_AL          4'he
`define CISD_WIDE_XCHG        24'h12fff1
`endif

/* File: core/cisd_cond_eval.v */
// Condition code evaluator for compact conditional branches and the wide exchange branch.
`include "cisd_map.vh"
module cisd_cond_eval (
  input  wire [3:0] cond,
  input  wire       flag_n,
  input  wire       flag_z,
  input  wire       flag_c,
  input  wire       flag_v,
  output reg        taken
);
  always @* begin
    case (cond)
      `CISD_COND_EQ: taken = flag_z;
      `CISD_COND_NE: taken = ~flag_z;
      `CISD_COND_CS: taken = flag_c;
      `CISD_COND_CC: taken = ~flag_c;
      `CISD_COND_MI: taken = flag_n;
      `CISD_COND_PL: taken = ~flag_n;
      `CISD_COND_VS: taken = flag_v;
      `CISD_COND_VC: taken = ~flag_v;
      `CISD_COND_HI: taken = flag_c & ~flag_z;
      `CISD_COND_LS: taken = ~flag_c | flag_z;
      `CISD_COND_GE: taken = (flag_n == flag_v);
      `CISD_COND_LT: taken = (flag_n != flag_v);
      `CISD_COND_GT: taken = ~flag_z & (flag_n == flag_v);
      `CISD_COND_LE: taken = flag_z | (flag_n != flag_v);
      default:       taken = 1'b0;
    endcase
  end
endmodule

/* File: sim/cisd_fetch_model.sv */
// Instruction fetch side that presents fetched words to the decoder.
module cisd_fetch_model (
  input  wire        ref_clk,
  input  wire        req_v,
  input  wire [31:0] req_w,
  output wire        fetch_valid,
  output wire [31:0] fetch_word
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [31:0] last_ff = 32'h0;
  always @(posedge ref_clk) if (req_v) last_ff <= req_w;
  // Between fetches the bus shows the inverse of the last word, never a stale copy.
  assign fetch_valid = req_v;
  assign fetch_word  = req_v ? req_w : ~last_ff;
endmodule

/* File: sim/cisd_decode_assertions.sv */
// Port checks for the compact decoder.
module cisd_chk (
  input wire        ref_clk,
  input wire        reset_n,
  input wire        fetch_valid,
  input wire [31:0] fetch_word,
  input wire [31:0] program_counter,
  input wire [3:0]  flags_nzcv,
  input wire        exc_enter,
  input wire        exc_return,
  input wire        state_compact_ff,
  input wire [15:0] instr_ff,
  input wire        wide_instr_ff,
  input wire        branch_taken_ff,
  input wire        push_ff,
  input wire        push_link_ff
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire [15:0] h = program_counter[1] ? fetch_word[31:16] : fetch_word[15:0];
  wire        q = fetch_valid && !exc_enter && !exc_return;
  wire        g = q && state_compact_ff;
  wire [3:0]  f = flags_nzcv;
  sequence s_exc_in;
    state_compact_ff && exc_enter;
  endsequence
  sequence s_exc_out;
    exc_return && !exc_enter;
  endsequence
  property p_exc_wide; exc_enter |=> !state_compact_ff; endproperty
  property p_exc_back; s_exc_in ##1 s_exc_out |=> state_compact_ff; endproperty
  property p_half; g |=> instr_ff == $past(h); endproperty
  property p_wide; q && !state_compact_ff |=> wide_instr_ff; endproperty
  property p_hi; g && h[15:8] == 8'hd8 |=> branch_taken_ff == $past(f[1] && !f[2]); endproperty
  property p_ge; g && h[15:8] == 8'hda |=> branch_taken_ff == $past(f[3] == f[0]); endproperty
  property p_lt; g && h[15:8] == 8'hdb |=> branch_taken_ff == $past(f[3] != f[0]); endproperty
  property p_le; g && h[15:8] == 8'hdd |=> branch_taken_ff == $past(f[2] || f[3] != f[0]); endproperty
  property p_push; g && h[15:9] == 7'h5a |=> push_ff && push_link_ff == $past(h[8]); endproperty
  property p_keep; !fetch_valid && !exc_enter && !exc_return |=> $stable(state_compact_ff); endproperty
  a_exc_wide: assert property (p_exc_wide) else $error("state not wide");
  a_exc_back: assert property (p_exc_back) else $error("state not restored");
  a_half: assert property (p_half) else $error("wrong halfword");
  a_wide: assert property (p_wide) else $error("wide word lost");
  a_hi: assert property (p_hi) else $error("higher test");
  a_ge: assert property (p_ge) else $error("ge test");
  a_lt: assert property (p_lt) else $error("lt test");
  a_le: assert property (p_le) else $error("le test");
  a_push: assert property (p_push) else $error("push link");
  a_keep: assert property (p_keep) else $error("state moved alone");
endmodule
bind cisd_decode cisd_chk u_chk (.ref_clk(ref_clk), .reset_n(reset_n),
  .fetch_valid(fetch_valid), .fetch_word(fetch_word), .program_counter(program_counter),
  .flags_nzcv(flags_nzcv), .exc_enter(exc_enter), .exc_return(exc_return),
  .state_compact_ff(state_compact_ff), .instr_ff(instr_ff), .wide_instr_ff(wide_instr_ff),
  .branch_taken_ff(branch_taken_ff), .push_ff(push_ff), .push_link_ff(push_link_ff));

/* File: sim/tb.sv */
// Self-checking bench for the compact decoder.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        req_v = 1'b0;
  logic        exc_enter = 1'b0;
  logic        exc_return = 1'b0;
  logic [31:0] req_w = 32'h0;
  logic [31:0] pc = 32'h0;
  logic [31:0] lo = 32'h0;
  logic [31:0] hi = 32'h0;
  logic [3:0]  fl = 4'h0;
  logic [15:0] hw = 16'h0;
  logic [31:0] ld = 32'h0;
  logic [31:0] exp_ld = 32'h0;
  wire         fetch_valid;
  wire  [31:0] fetch_word;
  int          failures = 0;
  int          n_tests = 0;
  int          ms = 0;
  cisd_fetch_model mem (.ref_clk(ref_clk), .req_v(req_v), .req_w(req_w),
    .fetch_valid(fetch_valid), .fetch_word(fetch_word));
  cisd_decode uut (.ref_clk(ref_clk), .reset_n(reset_n), .fetch_valid(fetch_valid),
    .fetch_word(fetch_word), .program_counter(pc), .stack_pointer(~pc), .flags_nzcv(fl),
    .xchg_target_low(lo), .xchg_target_high(hi), .exc_enter(exc_enter),
    .exc_return(exc_return), .load_data(lo ^ pc), .state_compact_ff(), .fetch_addr_ff(),
    .instr_ff(), .wide_instr_ff(), .wide_word_ff(), .branch_taken_ff(), .branch_target_ff(),
    .xchg_branch_ff(), .shift_op_ff(), .shift_by_reg_ff(), .shift_imm_ff(), .ls_size_ff(),
    .ls_offset_ff(), .ls_load_ff(), .addr_gen_ff(), .addr_gen_value_ff(), .push_ff(),
    .pop_ff(), .reg_list_ff(), .push_link_ff(), .pop_pc_ff(), .signed_load_ff());
  initial forever #12.5 ref_clk = ~ref_clk;
  function automatic logic cond(input logic [3:0] c, input logic [3:0] f);
    case (c)
      4'h0: cond = f[2];
      4'h1: cond = !f[2];
      4'h2: cond = f[1];
      4'h3: cond = !f[1];
      4'h4: cond = f[3];
      4'h5: cond = !f[3];
      4'h6: cond = f[0];
      4'h7: cond = !f[0];
      4'h8: cond = f[1] && !f[2];
      4'h9: cond = !f[1] || f[2];
      4'ha: cond = f[3] == f[0];
      4'hb: cond = f[3] != f[0];
      4'hc: cond = !f[2] && f[3] == f[0];
      4'hd: cond = f[2] || f[3] != f[0];
      default: cond = 1'b0;
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic issue(input logic [15:0] h);
    pc = $urandom;
    fl = 4'($urandom);
    req_w = pc[1] ? {h, pc[15:0]} : {pc[31:16], h};
    pc[0] = 1'b0;
    req_v = 1'b1;
    @(negedge ref_clk);
    if (ms == 1) chk(uut.instr_ff, h);
    chk(uut.fetch_addr_ff, ms ? {pc[31:1], 1'b0} : {pc[31:2], 2'h0});
  endtask
  task automatic go_compact();
    lo = $urandom | 32'h1;
    hi = ~lo;
    pc = $urandom;
    req_w = 32'he12fff11;
    req_v = 1'b1;
    @(negedge ref_clk);
    ms = 1;
    chk(uut.wide_word_ff, 32'he12fff11);
    chk(uut.fetch_addr_ff, {pc[31:2], 2'h0});
    chk(uut.state_compact_ff, 1);
    chk(uut.xchg_branch_ff, 1);
    chk(uut.branch_target_ff, {lo[31:1], 1'b0});
  endtask
  initial begin
    #20000;
    failures++;
    test_done();
  end
  initial begin
    void'($urandom(92));
    repeat (4) @(negedge ref_clk);
    reset_n = 1'b1;
    lo = 32'h1;
    issue(16'h4708);
    chk(uut.state_compact_ff, 0);
    $display("test refuse done");
    go_compact();
    for (int r = 0; r < 3; r++) begin
      for (int c = 0; c < 16; c++) begin
        hw = {4'hd, c[3:0], pc[7:0]};
        issue(hw);
        chk(uut.branch_taken_ff, cond(c[3:0], fl));
        if (c < 14) chk(uut.branch_target_ff, pc + {{23{hw[7]}}, hw[7:0], 1'b0});
      end
    end
    hw = {5'h1c, pc[10:0]};
    issue(hw);
    chk(uut.branch_taken_ff, 1);
    chk(uut.branch_target_ff, pc + {{20{hw[10]}}, hw[10:0], 1'b0});
    $display("test branch done");
    for (int k = 0; k < 7; k++) begin
      hw = (k < 3) ? {3'b000, k[1:0], pc[10:0]} :
                     {6'h10, (k == 6) ? 4'h7 : 4'(k - 1), pc[5:0]};
      issue(hw);
      chk(uut.shift_op_ff, (k < 3) ? k : k - 3);
      chk(uut.shift_by_reg_ff, k > 2);
      if (k < 3) chk(uut.shift_imm_ff, hw[10:6]);
    end
    $display("test shift done");
    for (int k = 0; k < 3; k++) begin
      hw = {k == 0 ? 5'h0d : k == 1 ? 5'h11 : 5'h0f, pc[10:0]};
      issue(hw);
      chk(uut.ls_size_ff, k);
      chk(uut.ls_offset_ff, {27'h0, hw[10:6]} << (2 - k));
      chk(uut.ls_load_ff, 1);
    end
    for (int k = 0; k < 3; k++) begin
      hw = {k == 0 ? 5'h09 : k == 1 ? 5'h13 : 5'h12, pc[10:0]};
      issue(hw);
      chk(uut.ls_size_ff, 0);
      chk(uut.ls_offset_ff, {22'h0, hw[7:0], 2'h0});
      chk(uut.ls_load_ff, k < 2);
    end
    for (int k = 0; k < 2; k++) begin
      hw = {4'ha, k[0], pc[10:0]};
      issue(hw);
      chk(uut.addr_gen_ff, 1);
      chk(uut.addr_gen_value_ff, (k ? ~pc : {pc[31:2], 2'h0}) + {22'h0, hw[7:0], 2'h0});
    end
    for (int k = 0; k < 3; k++) begin
      lo = $urandom;
      exp_ld = uut.signed_load_ff;
      hw = {4'h5, k != 1, k != 2, 1'b1, pc[8:0]};
      issue(hw);
      ld = lo ^ pc;
      if (k == 0) exp_ld = {{16{ld[15]}}, ld[15:0]};
      if (k == 1) exp_ld = {{24{ld[7]}}, ld[7:0]};
      chk(uut.signed_load_ff, exp_ld);
    end
    $display("test offset done");
    for (int k = 0; k < 2; k++) begin
      hw = {4'hb, k[0], 2'b10, pc[8:0]};
      issue(hw);
      chk(k ? uut.pop_ff : uut.push_ff, 1);
      chk(k ? uut.pop_pc_ff : uut.push_link_ff, hw[8]);
      chk(uut.reg_list_ff, hw[7:0]);
    end
    $display("test stack done");
    for (int k = 0; k < 2; k++) begin
      lo = $urandom & 32'hfffffffe;
      hi = ~lo & 32'hfffffffe;
      issue({8'h47, 1'b0, k[0], pc[2:0], 3'b000});
      ms = 0;
      chk(uut.state_compact_ff, 0);
      chk(uut.xchg_branch_ff, 1);
      chk(uut.branch_target_ff, k ? hi : lo);
      go_compact();
    end
    $display("test exchange done");
    req_v = 1'b0;
    exc_enter = 1'b1;
    @(negedge ref_clk);
    exc_enter = 1'b0;
    exc_return = 1'b1;
    chk(uut.state_compact_ff, 0);
    @(negedge ref_clk);
    exc_return = 1'b0;
    chk(uut.state_compact_ff, 1);
    $display("test exception done");
    reset_n = 1'b0;
    @(negedge ref_clk);
    chk(uut.state_compact_ff, 0);
    chk(uut.ls_size_ff, 3);
    reset_n = 1'b1;
    exc_return = 1'b1;
    @(negedge ref_clk);
    exc_return = 1'b0;
    chk(uut.state_compact_ff, 0);
    $display("test reset done");
    test_done();
  end
endmodule
